// >>> verilog/cdrf_params.svh
// offsets, field positions, reset values and timing counts for the divider and rf config bank
`ifndef CDRF_PARAMS_SVH
`define CDRF_PARAMS_SVH

// =====================================================================
// register offsets
`define CDRF_OFS_DIV_LOW      8'h86
`define CDRF_OFS_DIV_MID      8'h87
`define CDRF_OFS_DIV_HIGH     8'h88
`define CDRF_OFS_RF_CTRL      8'h89
`define CDRF_OFS_CAL_TIME     8'h8A
`define CDRF_OFS_CAL_BW       8'h8B
`define CDRF_OFS_CAL_CTRL     8'hC0
`define CDRF_OFS_STATUS       8'hC1

// =====================================================================
// reset values
`define CDRF_RST_DIV_LOW      8'h0B
`define CDRF_RST_DIV_MID      8'h00
`define CDRF_RST_DIV_HIGH     4'h0
`define CDRF_RST_ATT          4'h7
`define CDRF_RST_RF_OFF       1'b0
`define CDRF_RST_CAL_TIME     4'h7
`define CDRF_RST_CAL_BW       6'h04

// =====================================================================
// field positions
`define CDRF_RF_OFF_BIT       4
`define CDRF_ATT_MSB          3
`define CDRF_BW_MSB           5

// =====================================================================
// calibration timing: crystal periods per step and step offset
`define CDRF_CAL_XTAL_MULT    80
`define CDRF_CAL_STEP_MULT    7
`define CDRF_CAL_N_OFFSET     4

`endif

// >>> verilog/cdrf_pkg.sv
// types shared by the divider and rf config bank
package cdrf_pkg;

    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic       wr;
        logic       rd;
    } cdrf_bus_req_t;

    typedef struct packed {
        logic       rf_path_off;
        logic [3:0] if_attenuation_code;
        logic [5:0] filter_cal_bw_code;
    } cdrf_rf_cfg_t;

    typedef enum logic [1:0] {
        CDRF_CAL_IDLE = 2'b01,
        CDRF_CAL_RUN  = 2'b10
    } cdrf_cal_state_t;

endpackage : cdrf_pkg

// >>> verilog/cdrf_clk_div.sv
// clock output divider: toggles every n source cycles, every 2 for n of one, every two to the width for zero
`timescale 1ns/100ps
`default_nettype none
`include "cdrf_params.svh"

module cdrf_clk_div #(
    parameter int WIDTH = 20
) (
    input  wire logic             mclk,     // source clock
    input  wire logic             nrst,     // async reset, active low
    input  wire logic             ce,       // clock enable
    input  wire logic [WIDTH-1:0] div_val,  // divide value n
    output logic                  clk_out   // divided clock
);
    import cdrf_pkg::*;

    logic [WIDTH:0]   half_per;
    logic [WIDTH:0]   cnt_r;
    logic [WIDTH:0]   cnt_nxt;
    logic             at_end;

    // =====================================================================
    // half-period decode
    // zero means two to the width
    assign half_per = (div_val == '0) ? {1'b1, {WIDTH{1'b0}}} :
                      (div_val == {{(WIDTH-1){1'b0}}, 1'b1}) ?
                      (WIDTH+1)'(2) : {1'b0, div_val};
    // new value is compared at once against the count of the half-period in progress
    assign at_end   = (cnt_r >= half_per - (WIDTH+1)'(1));
    assign cnt_nxt  = at_end ? '0 : cnt_r + (WIDTH+1)'(1);

    // =====================================================================
    // toggle every half_per cycles: n, or 2 for n of one, or two to the width for zero
    // full scale divides by twice the max
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            cnt_r   <= '0;
            clk_out <= 1'b0;
        end else if (ce) begin
            cnt_r <= cnt_nxt;
            if (at_end) begin
                clk_out <= ~clk_out;
            end
        end
    end

    a_div_toggle: assert property (@(posedge mclk) disable iff (!nrst)
        ce && at_end && $stable(half_per) |=> (clk_out != $past(clk_out)) && cnt_r == '0)
        else $error("divider did not toggle at period end");

endmodule : cdrf_clk_div
`default_nettype wire

// >>> verilog/cdrf_config.sv
// divider, rf control and filter calibration configuration bank
`timescale 1ns/100ps
`default_nettype none
`include "cdrf_params.svh"
// How it works
// - the 20-bit divide value is high[3:0], then mid byte, then low byte.
// - a nonzero divide value n gives an output clock at source over 2n, least n is 2.
// - the all-ones divide value divides by twice two-to-twenty minus one.
// - a zero divide value counts as two to the twentieth.
// - rf path is disabled while the rf-off bit 4 is one, enabled while zero.
// - the 4-bit attenuation code sets 0.8 dB steps from 0 to 12 dB in double conversion.
// - the attenuation code resets to 7.
// - calibration lasts crystal period times 80 times 7 times the time setting plus 4.
// - during calibration the filter bandwidth comes from the 6-bit bandwidth code.

module cdrf_config #(
    parameter int DIV_W      = 20,
    parameter int XTAL_DIV   = 1     // source cycles per crystal period
) (
    input  wire logic                   mclk,          // 250 MHz clock
    input  wire logic                   nrst,          // async reset, active low
    input  wire logic                   ce,            // clock enable
    input  wire cdrf_pkg::cdrf_bus_req_t bus_req,      // register bus request
    output logic [7:0]                  bus_rdata,     // read data, one cycle later
    input  wire logic                   cal_start,     // calibration request pulse
    output logic                        clk_out,       // divided clock pin
    output logic                        rf_path_en,    // rf receive path enable
    output logic [3:0]                  if_attenuation_code, // attenuator code
    output logic                        cal_busy,      // calibration running
    output logic [5:0]                  filter_bw_sel  // filter bandwidth to analog
);
    import cdrf_pkg::*;

    // =====================================================================
    // registers
    logic [7:0]       div_low_r;
    logic [7:0]       div_mid_r;
    logic [3:0]       div_high_r;
    logic             rf_off_r;
    logic [3:0]       att_r;
    logic [3:0]       cal_time_r;
    logic [5:0]       cal_bw_r;
    logic [DIV_W-1:0] clock_divide_value;
    cdrf_rf_cfg_t     rf_cfg;

    // =====================================================================
    // address decode
    function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
        hit = (a == ofs);
    endfunction : hit

    wire wr_low  = bus_req.wr && hit(bus_req.addr, `CDRF_OFS_DIV_LOW);
    wire wr_mid  = bus_req.wr && hit(bus_req.addr, `CDRF_OFS_DIV_MID);
    wire wr_high = bus_req.wr && hit(bus_req.addr, `CDRF_OFS_DIV_HIGH);
    wire wr_rf   = bus_req.wr && hit(bus_req.addr, `CDRF_OFS_RF_CTRL);
    wire wr_time = bus_req.wr && hit(bus_req.addr, `CDRF_OFS_CAL_TIME);
    wire wr_bw   = bus_req.wr && hit(bus_req.addr, `CDRF_OFS_CAL_BW);
    wire wr_cal  = bus_req.wr && hit(bus_req.addr, `CDRF_OFS_CAL_CTRL);

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            div_low_r  <= `CDRF_RST_DIV_LOW;
            div_mid_r  <= `CDRF_RST_DIV_MID;
            div_high_r <= `CDRF_RST_DIV_HIGH;
            rf_off_r   <= `CDRF_RST_RF_OFF;
            att_r      <= `CDRF_RST_ATT;
            cal_time_r <= `CDRF_RST_CAL_TIME;
            cal_bw_r   <= `CDRF_RST_CAL_BW;
        end else if (ce) begin
            if (wr_low)  div_low_r  <= bus_req.wdata;
            if (wr_mid)  div_mid_r  <= bus_req.wdata;
            if (wr_high) div_high_r <= bus_req.wdata[3:0];
            if (wr_rf) begin
                rf_off_r <= bus_req.wdata[`CDRF_RF_OFF_BIT];
                att_r    <= bus_req.wdata[`CDRF_ATT_MSB:0];
            end
            if (wr_time) cal_time_r <= bus_req.wdata[3:0];
            if (wr_bw)   cal_bw_r   <= bus_req.wdata[`CDRF_BW_MSB:0];
        end
    end

    assign clock_divide_value = {div_high_r, div_mid_r, div_low_r};

    assign rf_cfg.rf_path_off         = rf_off_r;
    assign rf_cfg.if_attenuation_code = att_r;
    assign rf_cfg.filter_cal_bw_code  = cal_bw_r;

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            rf_path_en          <= 1'b1;
            if_attenuation_code <= `CDRF_RST_ATT;
        end else if (ce) begin
            rf_path_en          <= ~rf_cfg.rf_path_off;
            if_attenuation_code <= rf_cfg.if_attenuation_code;
        end
    end

    // =====================================================================
    // divider
    cdrf_clk_div #(
        .WIDTH   (DIV_W)
    ) u_div (
        .mclk    (mclk),
        .nrst    (nrst),
        .ce      (ce),
        .div_val (clock_divide_value),
        .clk_out (clk_out)
    );

    // =====================================================================
    // calibration timer
    // total cycles = xtal_div * 80 * 7 * (n + 4); max 19*560 = 10640 per xtal
    localparam int CAL_STEP = XTAL_DIV * `CDRF_CAL_XTAL_MULT * `CDRF_CAL_STEP_MULT;
    cdrf_cal_state_t cal_st_r;
    cdrf_cal_state_t cal_st_nxt;
    logic [31:0]     cal_len;
    logic [31:0]     cal_cnt_r;
    logic [31:0]     cal_cnt_nxt;
    wire             cal_go   = cal_start || (wr_cal && bus_req.wdata[0]);

    assign cal_len = 32'(CAL_STEP) * (32'(cal_time_r) + 32'(`CDRF_CAL_N_OFFSET));

    always_comb begin
        cal_st_nxt  = cal_st_r;
        cal_cnt_nxt = cal_cnt_r;
        case (cal_st_r)
            CDRF_CAL_IDLE: begin
                if (cal_go) begin
                    cal_st_nxt  = CDRF_CAL_RUN;
                    cal_cnt_nxt = cal_len - 32'd1;
                end
            end
            CDRF_CAL_RUN: begin
                if (cal_cnt_r == 32'd0) begin
                    cal_st_nxt = CDRF_CAL_IDLE;
                end else begin
                    cal_cnt_nxt = cal_cnt_r - 32'd1;
                end
            end
            default: cal_st_nxt = CDRF_CAL_IDLE;
        endcase
    end

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            cal_st_r  <= CDRF_CAL_IDLE;
            cal_cnt_r <= 32'd0;
        end else if (ce) begin
            cal_st_r  <= cal_st_nxt;
            cal_cnt_r <= cal_cnt_nxt;
        end
    end

    assign cal_busy = (cal_st_r == CDRF_CAL_RUN);

    // bandwidth during calibration
    // outside calibration the filter keeps its reset-default setting
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            filter_bw_sel <= `CDRF_RST_CAL_BW;
        end else if (ce) begin
            filter_bw_sel <= (cal_st_nxt == CDRF_CAL_RUN) ?
                             rf_cfg.filter_cal_bw_code : `CDRF_RST_CAL_BW;
        end
    end

    // =====================================================================
    // readback: config registers are write-only, status is readable
    wire [7:0] rd_mux = hit(bus_req.addr, `CDRF_OFS_STATUS) ?
                        {6'h00, rf_off_r, cal_busy} : 8'h00;

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            bus_rdata <= 8'h00;
        end else if (ce) begin
            bus_rdata <= bus_req.rd ? rd_mux : 8'h00;
        end
    end

    // =====================================================================
    // checks
    // rf path follows off bit
    a_rf_path_off: assert property (@(posedge mclk) disable iff (!nrst)
        ce && wr_rf |=> ##1 (rf_path_en == !$past(bus_req.wdata[4], 2)) || !$past(ce))
        else $error("rf path enable did not follow off bit");

    a_att_code: assert property (@(posedge mclk) disable iff (!nrst)
        ce && wr_rf ##1 ce |=> if_attenuation_code == $past(bus_req.wdata[3:0], 2))
        else $error("attenuation code did not follow write");

    a_div_concat: assert property (@(posedge mclk) disable iff (!nrst)
        ce && wr_mid |=> clock_divide_value[15:8] == $past(bus_req.wdata))
        else $error("mid divide byte not placed at 15:8");

    a_cal_len: assert property (@(posedge mclk) disable iff (!nrst)
        ce && cal_st_r == CDRF_CAL_IDLE && cal_go |=>
        cal_busy && cal_cnt_r == CAL_STEP * ($past(cal_time_r) + 4) - 1)
        else $error("calibration length wrong");

    a_cal_bw: assert property (@(posedge mclk) disable iff (!nrst)
        cal_busy && $stable(cal_bw_r) && $past(cal_busy) |-> filter_bw_sel == cal_bw_r)
        else $error("filter bandwidth not from code during calibration");

    a_att_reset: assert property (@(posedge mclk)
        $rose(nrst) && !$past(wr_rf) |-> att_r == 4'h7)
        else $error("attenuation reset value wrong");

    a_div_low_byte: assert property (@(posedge mclk) disable iff (!nrst)
        ce && wr_low |=> clock_divide_value[7:0] == $past(bus_req.wdata))
        else $error("low divide byte not placed at 7:0");

    a_div_high_nib: assert property (@(posedge mclk) disable iff (!nrst)
        ce && wr_high |=> clock_divide_value[19:16] == $past(bus_req.wdata[3:0]))
        else $error("high divide nibble not placed at 19:16");

    a_cal_keeps: assert property (@(posedge mclk) disable iff (!nrst)
        ce && cal_busy && cal_cnt_r != 32'd0 |=> cal_busy)
        else $error("calibration ended before its count ran out");

    a_bw_idle: assert property (@(posedge mclk) disable iff (!nrst)
        !cal_busy |-> filter_bw_sel == `CDRF_RST_CAL_BW)
        else $error("filter bandwidth not at default while idle");

    a_rd_zero: assert property (@(posedge mclk) disable iff (!nrst)
        ce && bus_req.rd && bus_req.addr == `CDRF_OFS_DIV_LOW |=> bus_rdata == 8'h00)
        else $error("write-only register read back nonzero");

endmodule : cdrf_config
`default_nettype wire

// >>> verif/cdrf_host_model.sv
// host-side model: measures the divided clock in source cycles
`timescale 1ns/100ps
`default_nettype none

module cdrf_host_model (
    input  wire logic        mclk,    // source clock
    input  wire logic        nrst,    // async reset, active low
    input  wire logic        clk_out, // divided clock from the device
    output logic [21:0]      period   // last rise-to-rise spacing
);
    logic        prev_r;
    logic [21:0] cnt_r;

    // =====
    // period capture, sampled like a host timer on the source clock
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            prev_r <= 1'b0;
            cnt_r  <= 22'h000000;
            period <= 22'h000000;
        end else begin
            prev_r <= clk_out;
            cnt_r  <= (clk_out & ~prev_r) ? 22'h000001 : cnt_r + 22'h000001;
            if (clk_out & ~prev_r) begin
                period <= cnt_r;
            end
        end
    end
endmodule : cdrf_host_model
`default_nettype wire

// >>> verif/cdrf_config_tb.sv
// self-checking bench for the divider and rf config bank
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, e, g) begin checks_done++; if ((g) !== (e)) begin errors++; \
    $display("CHECK FAILED %s exp %0h got %0h", nm, e, g); end end

module cdrf_config_tb;
    import cdrf_pkg::*;
    logic          mclk, nrst, ce, cal_start, clk_out, rf_path_en, cal_busy;
    cdrf_bus_req_t bus_req;
    logic [7:0]    bus_rdata, lfsr_r, d;
    logic          hold_v;
    logic [3:0]    if_attenuation_code;
    logic [5:0]    filter_bw_sel;
    logic [21:0]   period;
    int            errors, checks_done, cyc;
    logic [19:0]   div_tab [5] = '{20'h00002, 20'h00001, 20'h00003, 20'h00103, 20'h0000B};
    logic [5:0]    bw_tab [5] = '{6'h04, 6'h0D, 6'h16, 6'h1F, 6'h27};
    logic [3:0]    tm_tab [5] = '{4'h0, 4'h7, 4'h0, 4'hF, 4'h0};

    cdrf_config DUT (.mclk(mclk), .nrst(nrst), .ce(ce), .bus_req(bus_req),
        .bus_rdata(bus_rdata), .cal_start(cal_start), .clk_out(clk_out),
        .rf_path_en(rf_path_en), .if_attenuation_code(if_attenuation_code),
        .cal_busy(cal_busy), .filter_bw_sel(filter_bw_sel));
    cdrf_host_model HOST (.mclk(mclk), .nrst(nrst), .clk_out(clk_out), .period(period));

    always #2 mclk = ~mclk;

    // =====
    // expectations
    function automatic logic [7:0] lfsr_next(input logic [7:0] s);
        return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
    endfunction : lfsr_next
    function automatic logic [21:0] exp_period(input logic [19:0] n);
        if (n == 20'h00000) return 22'h200000;
        if (n == 20'h00001) return 22'h000004;
        return {1'b0, n, 1'b0};
    endfunction : exp_period
    function automatic logic [31:0] exp_cal_len(input logic [3:0] t);
        return 32'h00000230 * ({28'h0000000, t} + 32'h00000004);
    endfunction : exp_cal_len

    // =====
    // bus and scenario tasks
    task automatic wrap_up;
        $display("checks %0d errors %0d", checks_done, errors);
        if (errors == 0 && checks_done > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask : wrap_up
    task automatic bus_wr(input logic [7:0] a, input logic [7:0] wd);
        bus_req <= '{addr: a, wdata: wd, wr: 1'b1, rd: 1'b0};
        @(posedge mclk);
        bus_req <= '0;
        @(posedge mclk);
    endtask : bus_wr
    task automatic bus_rd(input logic [7:0] a, input logic [7:0] e, input string nm);
        bus_req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        @(posedge mclk);
        bus_req <= '0;
        #1;
        `CHK(nm, e, bus_rdata)
        @(posedge mclk);
    endtask : bus_rd
    // unused top bits carry random junk that must be ignored
    task automatic wr_div(input logic [19:0] n);
        bus_wr(8'h88, {lfsr_r[7:4], n[19:16]});
        bus_wr(8'h87, n[15:8]);
        bus_wr(8'h86, n[7:0]);
    endtask : wr_div
    task automatic check_period(input logic [19:0] n);
        repeat (3) @(posedge clk_out);
        repeat (2) @(posedge mclk);
        #1;
        `CHK("divider period", exp_period(n), period)
        @(posedge mclk);
    endtask : check_period
    // a full 2^20 count is too long to run, so only the hold is shown
    task automatic hold_check(input logic [19:0] n);
        logic v;
        logic ok;
        wr_div(n);
        #1;
        v = clk_out;
        ok = 1'b1;
        repeat (3000) begin
            @(posedge mclk);
            #1;
            if (clk_out !== v) ok = 1'b0;
        end
        `CHK("divider hold", 1'b1, ok)
        @(posedge mclk);
    endtask : hold_check
    task automatic cal_run(input logic by_reg, input logic [3:0] t, input logic [5:0] bw);
        int n;
        bus_wr(8'h8A, {lfsr_r[7:5], 1'b0, t});
        bus_wr(8'h8B, {lfsr_r[1:0], bw});
        if (by_reg) bus_req <= '{addr: 8'hC0, wdata: 8'h01, wr: 1'b1, rd: 1'b0};
        else cal_start <= 1'b1;
        @(posedge mclk);
        bus_req <= '0;
        cal_start <= 1'b0;
        n = 0;
        #1;
        `CHK("bandwidth during cal", bw, filter_bw_sel)
        while (cal_busy === 1'b1 && n < 20000) begin
            n++;
            @(posedge mclk);
            cal_start <= (n == 100);
            #1;
        end
        `CHK("cal length", exp_cal_len(t), 32'(n))
        `CHK("bandwidth after cal", 6'h04, filter_bw_sel)
        @(posedge mclk);
    endtask : cal_run

    // =====
    // cycle ceiling
    always @(posedge mclk) begin
        cyc++;
        if (cyc == 60000) begin
            errors++;
            wrap_up();
        end
    end

    initial begin
        mclk = 1'b0;
        nrst = 1'b0;
        ce = 1'b1;
        cal_start = 1'b0;
        bus_req = '0;
        lfsr_r = 8'h33;
        repeat (4) @(posedge mclk);
        nrst <= 1'b1;
        @(posedge mclk);
        #1;
        `CHK("reset attenuation", 4'h7, if_attenuation_code)
        `CHK("reset rf path", 1'b1, rf_path_en)
        `CHK("reset bandwidth", 6'h04, filter_bw_sel)
        `CHK("reset busy", 1'b0, cal_busy)
        @(posedge mclk);
        check_period(20'h0000B);
        for (int i = 0; i < 6; i++) begin
            d = lfsr_r;
            wr_div(i == 5 ? {12'h000, d} : div_tab[i]);
            check_period(i == 5 ? {12'h000, d} : div_tab[i]);
            lfsr_r = lfsr_next(lfsr_r);
        end
        hold_check(20'hFFFFF);
        hold_check(20'h00000);
        wr_div(20'h00002);
        check_period(20'h00002);
        // clock enable low must freeze the divider
        ce <= 1'b0;
        @(posedge mclk);
        #1;
        hold_v = clk_out;
        repeat (8) @(posedge mclk);
        #1;
        `CHK("ce freeze", hold_v, clk_out)
        @(posedge mclk);
        ce <= 1'b1;
        for (int i = 0; i < 16; i++) begin
            d = {lfsr_r[7:5], lfsr_r[0], i[3:0]};
            bus_wr(8'h89, d);
            #1;
            `CHK("attenuation code", i[3:0], if_attenuation_code)
            `CHK("rf path enable", ~d[4], rf_path_en)
            lfsr_r = lfsr_next(lfsr_r);
            @(posedge mclk);
        end
        bus_rd(8'hC1, {6'h00, d[4], 1'b0}, "status");
        bus_wr(8'h8C, 8'h0A);
        #1;
        `CHK("unmapped write", d[3:0], if_attenuation_code)
        @(posedge mclk);
        // host keeps single-conversion codes inside 4 to A
        bus_wr(8'h89, 8'h0A);
        #1;
        `CHK("single conversion code", 4'hA, if_attenuation_code)
        @(posedge mclk);
        bus_rd(8'h86, 8'h00, "divider low read");
        bus_rd(8'h89, 8'h00, "write-only read");
        bus_rd(8'h55, 8'h00, "unmapped read");
        // default time setting sits among the runs
        for (int i = 0; i < 5; i++) cal_run(i[0], tm_tab[i], bw_tab[i]);
        wrap_up();
    end
endmodule : cdrf_config_tb
`default_nettype wire
